// ---- src/acc_pkg.sv ----
// How it works
// - all conversions begin on a trigger strobe
// - convert on read fall or start rise
// - host aligns trigger edges to clock falls
// - trigger edge restarts the internal oscillator
// - start strobe works without chip select
// - write rise, start fall or a clock count after read fall opens sampling
// - host leaves two clock periods of sampling
// - interrupt modes give one conversion per trigger
// - auto power-down only in interrupt modes
// - read strobe clocks the continuous modes
// - dual interrupt needs 8/10 bit, single-ended
// - mode 00 mono interrupt, read or start
// - mode 01 dual interrupt, start only
// - mode 10 mono continuous on read
// - mode 11 dual continuous, channel pair
// - mono conversion takes 5 or 6 clocks
// - dual conversion takes 10 or 12 clocks
// - read mono: data at ready, rise clears
// - start modes: read fall clears, drives data
package acc_pkg;
  localparam int DW = 10;
  localparam logic [1:0] MODE_MONO_INT = 2'h0;
  localparam logic [1:0] MODE_DUAL_INT = 2'h1;
  localparam logic [1:0] MODE_MONO_CONT = 2'h2;
  localparam logic [1:0] MODE_DUAL_CONT = 2'h3;
  localparam logic [1:0] SEL_CW_A = 2'h0;
  localparam logic [1:0] SEL_CW_B = 2'h1;
  localparam int SEL_HI = 9;
  localparam int SEL_LO = 8;
  localparam int CWA_CLKSRC_BIT = 5;
  localparam int CWA_INTYPE_BIT = 4;
  localparam int CWA_MODE_HI = 3;
  localparam int CWA_MODE_LO = 2;
  localparam int CWB_AUTOPD_BIT = 7;
  localparam int CWB_TRIG_BIT = 6;
  localparam int CWB_RES_HI = 5;
  localparam int CWB_RES_LO = 4;
  localparam logic [1:0] RES_4 = 2'h1;
  localparam logic [9:0] CWA_RST = 10'h000;
  localparam logic [9:0] CWB_RST = 10'h000;
  localparam logic [3:0] CONV_MONO_EXT = 4'h5;
  localparam logic [3:0] CONV_MONO_INT = 4'h6;
  localparam logic [3:0] CONV_DUAL_EXT = 4'hA;
  localparam logic [3:0] CONV_DUAL_INT = 4'hC;
  localparam logic [2:0] RESTART_MONO = 3'h2;
  localparam logic [2:0] RESTART_DUAL = 3'h7;
  localparam logic [1:0] OSC_DIV = 2'h2;
  localparam logic [1:0] EXT_HALF = 2'h2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS = 100;
  localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WR_LOW_CYC = 4'h2;
  localparam logic [3:0] RD_LOW_CYC = 4'h3;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [1:0] OP_WRCFG = 2'h1;
  localparam logic [1:0] OP_START = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_READY, ST_OUT} acc_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_WR, H_SETTLE, H_ALIGN, H_RD, H_GAP} acc_host_st_t;
endpackage : acc_pkg

// ---- src/acc_link_if.sv ----
`timescale 1ns/1ps
interface acc_link_if;
  import acc_pkg::*;
  logic rd_n;
  logic wr_n;
  logic cs_n;
  logic conv_start_strobe_n_n;
  logic ext_clk;
  logic int_n;
  logic [DW-1:0] h_d;
  logic h_oe;
  logic [DW-1:0] d_d;
  logic d_oe;
  logic [DW-1:0] db;
  // resolved shared data bus; undriven bus reads as zero
  assign db = d_oe ? d_d : (h_oe ? h_d : '0);
  modport dev (input rd_n, wr_n, cs_n, conv_start_strobe_n_n, ext_clk, db, output int_n, d_d, d_oe);
  modport host (output rd_n, wr_n, cs_n, conv_start_strobe_n_n, ext_clk, h_d, h_oe, input int_n, db);
endinterface : acc_link_if

// ---- src/acc_tick.sv ----
`timescale 1ns/1ps
module acc_tick (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ext_src_i,
  input wire logic ext_clk_i,
  input wire logic start_i,
  output logic tick_o
);
  import acc_pkg::*;
  logic ext_q_ff;
  logic [1:0] div_ff;
  logic tick_ff;
  wire int_wrap = (div_ff == OSC_DIV - 2'h1);
  // trigger edge restarts the divider, so only the external clock needs strobe alignment
  wire [1:0] nxt_div = (start_i || int_wrap) ? 2'h0 : div_ff + 2'h1;
  wire ext_rise = ext_clk_i & ~ext_q_ff;
  wire nxt_tick = ext_src_i ? ext_rise : (int_wrap & ~start_i);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ext_q_ff <= 1'b0;
      div_ff <= 2'h0;
      tick_ff <= 1'b0;
    end else begin
      ext_q_ff <= ext_clk_i;
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end
  assign tick_o = tick_ff;
endmodule : acc_tick

// ---- src/acc_dev.sv ----
`timescale 1ns/1ps
module acc_dev (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  acc_link_if.dev lk,
  input wire logic [acc_pkg::DW-1:0] ain_a_i,
  input wire logic [acc_pkg::DW-1:0] ain_b_i,
  output logic sampling_o,
  output logic pwrdn_o,
  output logic busy_o,
  output logic [1:0] mode_o
);
  import acc_pkg::*;
  logic rd_q_ff;
  logic wr_q_ff;
  logic cs_q_ff;
  logic cst_q_ff;
  logic [9:0] cwa_ff;
  logic [9:0] cwb_ff;
  acc_dev_st_t st_ff;
  acc_dev_st_t nxt_st;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic int_ff;
  logic nxt_int;
  logic doe_ff;
  logic nxt_doe;
  logic [DW-1:0] dout_ff;
  logic [DW-1:0] nxt_dout;
  logic sec_ff;
  logic nxt_sec;
  logic ph_ff;
  logic nxt_ph;
  logic [DW-1:0] cap0_ff;
  logic [DW-1:0] nxt_cap0;
  logic [DW-1:0] cap1_ff;
  logic [DW-1:0] nxt_cap1;
  logic [DW-1:0] h0_ff;
  logic [DW-1:0] nxt_h0;
  logic [DW-1:0] h1_ff;
  logic [DW-1:0] nxt_h1;
  logic [DW-1:0] pend_ff;
  logic [DW-1:0] nxt_pend;
  logic [2:0] rs_ff;
  logic samp_ff;
  logic pd_ff;
  logic tick;

  // edges of the host strobes, inputs are synchronous to ref_clk_i
  wire rd_fall = rd_q_ff & ~lk.rd_n;
  wire rd_rise = ~rd_q_ff & lk.rd_n;
  wire cs_fall = cs_q_ff & ~lk.cs_n;
  wire wr_rise = ~wr_q_ff & lk.wr_n & ~lk.cs_n;
  wire cst_fall = cst_q_ff & ~lk.conv_start_strobe_n_n;
  wire cst_rise = ~cst_q_ff & lk.conv_start_strobe_n_n;

  wire [1:0] mode = cwa_ff[CWA_MODE_HI:CWA_MODE_LO];
  wire ext_src = cwa_ff[CWA_CLKSRC_BIT];
  wire [1:0] wsel = lk.db[SEL_HI:SEL_LO];
  wire wr_a = wr_rise && (wsel == SEL_CW_A);
  wire wr_b = wr_rise && (wsel == SEL_CW_B);
  wire cont_mode = mode[1];
  wire dual = mode[0];
  wire dual_cont = (mode == MODE_DUAL_CONT);
  // mode 01 only takes the start strobe, mode 00 takes either by selection
  wire use_cst = (mode == MODE_DUAL_INT) ||
    ((mode == MODE_MONO_INT) && cwb_ff[CWB_TRIG_BIT]);
  // dual continuous converts on odd read falls only, the even ones drain the pair
  wire rd_trig = rd_fall && !lk.cs_n && !use_cst && !(dual_cont && ph_ff);
  wire cst_trig = cst_rise && use_cst;
  wire idle = (st_ff == ST_IDLE);
  wire trig = idle && (rd_trig || cst_trig);
  wire [3:0] need = dual ? (ext_src ? CONV_DUAL_EXT : CONV_DUAL_INT)
                         : (ext_src ? CONV_MONO_EXT : CONV_MONO_INT);
  wire conv_end = (st_ff == ST_CONV) && tick && (cnt_ff == need - 4'h1);

  acc_tick u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ext_src_i(ext_src),
    .ext_clk_i(lk.ext_clk),
    .start_i(rd_fall || cst_fall || cst_rise),
    .tick_o(tick)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_int = int_ff;
    nxt_doe = doe_ff;
    nxt_dout = dout_ff;
    nxt_sec = sec_ff;
    nxt_ph = ph_ff;
    nxt_cap0 = cap0_ff;
    nxt_cap1 = cap1_ff;
    nxt_h0 = h0_ff;
    nxt_h1 = h1_ff;
    nxt_pend = pend_ff;
    if (cont_mode && rd_rise) begin
      nxt_doe = 1'b0;
    end
    // each read fall in continuous modes puts the last finished result out
    if (cont_mode && rd_fall && !lk.cs_n) begin
      nxt_doe = 1'b1;
      nxt_dout = (dual && ph_ff) ? pend_ff : h0_ff;
      if (dual) begin
        nxt_ph = ~ph_ff;
      end
      // odd fall parks B, the conversion it starts must not split the pair in flight
      if (dual && !ph_ff) begin
        nxt_pend = h1_ff;
      end
    end
    case (st_ff)
      ST_IDLE: begin
        if (trig) begin
          nxt_st = ST_CONV;
          nxt_cnt = 4'h0;
          nxt_cap0 = ain_a_i;
          nxt_cap1 = ain_b_i;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          if (cont_mode) begin
            nxt_h0 = cap0_ff;
            nxt_h1 = cap1_ff;
            nxt_st = ST_IDLE;
          end else begin
            nxt_int = 1'b1;
            nxt_sec = 1'b0;
            nxt_st = ST_READY;
          end
        end else if (tick) begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      ST_READY: begin
        if (!use_cst) begin
          // read held low since the trigger: data follows the interrupt
          nxt_doe = 1'b1;
          nxt_dout = cap0_ff;
          if (rd_rise) begin
            nxt_int = 1'b0;
            nxt_doe = 1'b0;
            nxt_st = ST_IDLE;
          end
        end else if (rd_fall && !lk.cs_n) begin
          nxt_int = 1'b0;
          nxt_doe = 1'b1;
          nxt_dout = sec_ff ? cap1_ff : cap0_ff;
          nxt_st = ST_OUT;
        end
      end
      ST_OUT: begin
        if (rd_rise) begin
          nxt_doe = 1'b0;
          if (dual && !sec_ff) begin
            nxt_sec = 1'b1;
            nxt_st = ST_READY;
          end else begin
            nxt_sec = 1'b0;
            nxt_st = ST_IDLE;
          end
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // sampling window: opens on write rise, start fall or a clock count after read fall
  wire [2:0] restart = dual_cont ? RESTART_DUAL : RESTART_MONO;
  wire [2:0] nxt_rs = rd_trig && idle ? restart
                    : ((tick && rs_ff != 3'h0) ? rs_ff - 3'h1 : rs_ff);
  wire samp_open = wr_rise || (cst_fall && use_cst) || (tick && rs_ff == 3'h1);
  wire nxt_samp = trig ? 1'b0 : (samp_open ? 1'b1 : samp_ff);
  // power-down only reachable through the interrupt states
  wire pd_set = conv_end && !cont_mode && cwb_ff[CWB_AUTOPD_BIT];
  wire pd_clr = (cs_fall && !use_cst) || (cst_fall && use_cst);
  wire nxt_pd = pd_set ? 1'b1 : (pd_clr ? 1'b0 : pd_ff);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_q_ff <= 1'b1;
      wr_q_ff <= 1'b1;
      cs_q_ff <= 1'b1;
      cst_q_ff <= 1'b1;
      cwa_ff <= CWA_RST;
      cwb_ff <= CWB_RST;
    end else begin
      rd_q_ff <= lk.rd_n;
      wr_q_ff <= lk.wr_n;
      cs_q_ff <= lk.cs_n;
      cst_q_ff <= lk.conv_start_strobe_n_n;
      if (wr_a) begin
        cwa_ff <= lk.db;
      end
      if (wr_b) begin
        cwb_ff <= lk.db;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      int_ff <= 1'b0;
      doe_ff <= 1'b0;
      dout_ff <= '0;
      sec_ff <= 1'b0;
      ph_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      int_ff <= nxt_int;
      doe_ff <= nxt_doe;
      dout_ff <= nxt_dout;
      sec_ff <= nxt_sec;
      // a new write restarts the read pairing of dual continuous mode
      ph_ff <= wr_rise ? 1'b0 : nxt_ph;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cap0_ff <= '0;
      cap1_ff <= '0;
      h0_ff <= '0;
      h1_ff <= '0;
      pend_ff <= '0;
      rs_ff <= 3'h0;
      samp_ff <= 1'b0;
      pd_ff <= 1'b0;
    end else begin
      cap0_ff <= nxt_cap0;
      cap1_ff <= nxt_cap1;
      h0_ff <= nxt_h0;
      h1_ff <= nxt_h1;
      pend_ff <= nxt_pend;
      rs_ff <= nxt_rs;
      samp_ff <= nxt_samp;
      pd_ff <= nxt_pd;
    end
  end

  // stay off the bus only while the write strobe is low; the host drives its configuration word one cycle past the write rise
  wire rd_sel_ok = lk.wr_n;
  assign lk.int_n = ~int_ff;
  assign lk.d_oe = doe_ff && rd_sel_ok;
  assign lk.d_d = dout_ff;
  assign sampling_o = samp_ff;
  assign pwrdn_o = pd_ff;
  assign busy_o = !idle;
  assign mode_o = mode;
endmodule : acc_dev

// ---- src/acc_host.sv ----
`timescale 1ns/1ps
module acc_host (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  acc_link_if.host lk,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import acc_pkg::*;
  acc_host_st_t st_ff;
  logic [3:0] cnt_ff;
  logic [9:0] cfg_ff;
  logic [1:0] res_ff;
  logic [DW-1:0] data_ff;
  logic [31:0] prdata_ff;
  logic err_ff;
  logic wi_ff;
  logic [1:0] hc_ff;
  logic ext_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic cs_n_ff;
  logic cst_n_ff;
  logic hoe_ff;

  wire setup = psel_i && !penable_i;
  wire acc_wr = psel_i && penable_i && pwrite_i;
  wire a_cmd = (paddr_i == REG_CMD);
  wire a_cfg = (paddr_i == REG_CFG);
  wire a_stat = (paddr_i == REG_STAT);
  wire a_data = (paddr_i == REG_DATA);
  wire mapped = a_cmd || a_cfg || a_stat || a_data;
  wire idle = (st_ff == H_IDLE);
  wire go = acc_wr && a_cmd && idle;
  wire [1:0] op = pwdata_i[1:0];
  // dual interrupt mode is refused unless 8/10 bit and single-ended
  wire bad_cfg = (cfg_ff[SEL_HI:SEL_LO] == SEL_CW_A) &&
    (cfg_ff[CWA_MODE_HI:CWA_MODE_LO] == MODE_DUAL_INT) &&
    (cfg_ff[CWA_INTYPE_BIT] || res_ff == RES_4);
  wire ext_wrap = (hc_ff == EXT_HALF - 2'h1);
  // trigger strobe edges (read fall, start rise) land with the conversion clock fall, well ahead of its rise
  wire ext_fall = ext_wrap && ext_ff;
  wire cnt_done = (cnt_ff == 4'h0);
  wire [3:0] cnt_dec = cnt_done ? 4'h0 : cnt_ff - 4'h1;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hc_ff <= 2'h0;
      ext_ff <= 1'b0;
    end else begin
      hc_ff <= ext_wrap ? 2'h0 : hc_ff + 2'h1;
      ext_ff <= ext_wrap ? ~ext_ff : ext_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg_ff <= 10'h000;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (acc_wr && a_cfg) begin
        cfg_ff <= pwdata_i[9:0];
      end
      if (setup) begin
        prdata_ff <= a_cfg ? {22'h00_0000, cfg_ff}
                   : a_stat ? {28'h000_0000, ~lk.int_n, err_ff, 1'b0, !idle}
                   : a_data ? {22'h00_0000, data_ff} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= H_IDLE;
      cnt_ff <= 4'h0;
      res_ff <= 2'h0;
      data_ff <= '0;
      err_ff <= 1'b0;
      wi_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      cst_n_ff <= 1'b1;
      hoe_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_dec;
      case (st_ff)
        H_IDLE: begin
          if (go) begin
            err_ff <= (op == OP_WRCFG) && bad_cfg;
            wi_ff <= pwdata_i[2];
            if (op == OP_WRCFG && !bad_cfg) begin
              st_ff <= H_WR;
              cnt_ff <= WR_LOW_CYC;
              wr_n_ff <= 1'b0;
              cs_n_ff <= 1'b0;
              hoe_ff <= 1'b1;
              if (cfg_ff[SEL_HI:SEL_LO] == SEL_CW_B) begin
                res_ff <= cfg_ff[CWB_RES_HI:CWB_RES_LO];
              end
            end else if (op == OP_START) begin
              st_ff <= H_SETTLE;
              cnt_ff <= SETTLE_CYC;
              cst_n_ff <= 1'b0;
            end else if (op == OP_READ) begin
              st_ff <= H_ALIGN;
              cs_n_ff <= 1'b0;
            end
          end
        end
        H_WR: begin
          if (cnt_done) begin
            wr_n_ff <= 1'b1;
            st_ff <= H_GAP;
            cnt_ff <= SETTLE_CYC;
          end
        end
        H_SETTLE: begin
          if (cnt_done && ext_fall) begin
            cst_n_ff <= 1'b1;
            st_ff <= H_GAP;
            cnt_ff <= SETTLE_CYC;
          end
        end
        H_ALIGN: begin
          if (ext_fall) begin
            rd_n_ff <= 1'b0;
            st_ff <= H_RD;
            cnt_ff <= RD_LOW_CYC;
          end
        end
        H_RD: begin
          if (cnt_done && (!wi_ff || !lk.int_n)) begin
            wi_ff <= 1'b0;
            if (!wi_ff) begin
              data_ff <= lk.db;
              rd_n_ff <= 1'b1;
              st_ff <= H_GAP;
              cnt_ff <= SETTLE_CYC;
            end
          end
        end
        H_GAP: begin
          hoe_ff <= 1'b0;
          cs_n_ff <= 1'b1;
          if (cnt_done) begin
            st_ff <= H_IDLE;
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign lk.rd_n = rd_n_ff;
  assign lk.wr_n = wr_n_ff;
  assign lk.cs_n = cs_n_ff;
  assign lk.conv_start_strobe_n_n = cst_n_ff;
  assign lk.ext_clk = ext_ff;
  assign lk.h_d = cfg_ff;
  assign lk.h_oe = hoe_ff;
  assign prdata_o = prdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
endmodule : acc_host

// ---- verification/acc_link_properties.sv ----
`timescale 1ns/1ps
module acc_link_properties (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic conv_start_strobe_n_n,
  input wire logic ext_clk,
  input wire logic int_n,
  input wire logic h_oe,
  input wire logic d_oe
);
  logic rd_q_ff;
  logic [3:0] rd_age_ff;
  logic [3:0] nxt_rd_age;
  // saturating age of the last read strobe edge, the cause window for later checks
  assign nxt_rd_age = (rd_n != rd_q_ff) ? 4'h0 :
                      ((rd_age_ff == 4'hF) ? 4'hF : rd_age_ff + 4'h1);
  always_ff @(posedge ref_clk_i) begin
    rd_q_ff <= rd_n;
    rd_age_ff <= rst_i ? 4'hF : nxt_rd_age;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence ext_wave;
    ##1 ext_clk ##1 !ext_clk [*2] ##1 ext_clk;
  endsequence
  sequence done_quiet;
    ##3 int_n [*6];
  endsequence
  AST_NO_CONTEND: assert property (!(d_oe && h_oe))
    else $error("both ends drive the data bus");
  AST_WR_QUIET: assert property ($rose(wr_n) |-> !d_oe)
    else $error("device drives bus at the end of a write");
  AST_RD_RISE_FREE: assert property ($rose(rd_n) |-> ##[1:3] !d_oe)
    else $error("bus not released after read rise");
  AST_INT_CLR_RISE: assert property ($rose(rd_n) && !int_n |-> ##[1:3] int_n)
    else $error("done flag not cleared by read rise");
  AST_INT_CLR_CAUSE: assert property ($rose(int_n) |-> rd_age_ff <= 4'h4)
    else $error("done flag cleared without a read edge");
  AST_DOE_CAUSE: assert property ($rose(d_oe) |-> !rd_n && (rd_age_ff <= 4'h4 || !int_n))
    else $error("data driven without read or done");
  AST_NO_EARLY_DONE: assert property (($fell(rd_n) || $rose(conv_start_strobe_n_n)) |-> done_quiet)
    else $error("done flag too soon after trigger");
  AST_EXT_WAVE: assert property ($rose(ext_clk) |-> ext_wave)
    else $error("external conversion clock period wrong");
endmodule : acc_link_properties

// ---- verification/adc_conversion_trigger_control_bench.sv ----
`timescale 1ns/1ps
module adc_conversion_trigger_control_bench;
  import acc_pkg::*;
  typedef struct packed {
    logic [9:0] cwa;
    logic [9:0] cwb;
    logic st;
    logic [2:0] nrd;
    logic [3:0] chk;
    logic [3:0] bsel;
    logic pd;
  } acc_row_t;
  logic ref_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, last_err;
  logic sampling, pwrdn, busy, cst_q, int_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [DW-1:0] ain_a, ain_b;
  logic [1:0] mode;
  int err_count = 0;
  int total_checks = 0;
  int since_start = 0;
  int conv_len = 0;
  int int_falls = 0;
  int busy_cnt = 0;
  // config word B, then A; start or read; reads; checked reads; channel B reads; power-down
  acc_row_t rows [7] = '{
    '{10'h000, 10'h180, 1'b0, 3'h1, 4'h1, 4'h0, 1'b1},
    '{10'h000, 10'h1C0, 1'b1, 3'h1, 4'h1, 4'h0, 1'b1},
    '{10'h004, 10'h140, 1'b1, 3'h2, 4'h3, 4'h2, 1'b0},
    '{10'h020, 10'h1C0, 1'b1, 3'h1, 4'h1, 4'h0, 1'b1},
    '{10'h008, 10'h180, 1'b0, 3'h2, 4'h2, 4'h0, 1'b0},
    '{10'h00C, 10'h100, 1'b0, 3'h4, 4'hC, 4'h8, 1'b0},
    '{10'h020, 10'h100, 1'b0, 3'h1, 4'h1, 4'h0, 1'b0}};
  acc_link_if lk ();
  acc_host acc_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lk(lk), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  acc_dev acc_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lk(lk), .ain_a_i(ain_a),
    .ain_b_i(ain_b), .sampling_o(sampling), .pwrdn_o(pwrdn), .busy_o(busy), .mode_o(mode));
  acc_link_properties acc_link_properties_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .rd_n(lk.rd_n), .wr_n(lk.wr_n), .conv_start_strobe_n_n(lk.conv_start_strobe_n_n), .ext_clk(lk.ext_clk),
    .int_n(lk.int_n), .h_oe(lk.h_oe), .d_oe(lk.d_oe));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // link monitor: conversion length from start rise to done fall, done and busy counts
  always @(posedge ref_clk_i) begin
    cst_q <= lk.conv_start_strobe_n_n;
    int_q <= lk.int_n;
    since_start <= (lk.conv_start_strobe_n_n === 1'b1 && cst_q === 1'b0) ? 1 : since_start + 1;
    busy_cnt <= busy_cnt + ((busy === 1'b1) ? 1 : 0);
    if (lk.int_n === 1'b0 && int_q === 1'b1) begin
      conv_len <= since_start;
      int_falls <= int_falls + 1;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic timeout();
    err_count++;
    $display("BAD t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask : timeout
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) timeout();
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input int bitn);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0, s);
      n++;
    end while (s[bitn] !== (bitn == 0 ? 1'b0 : 1'b1) && n < 200);
    if (n >= 200) timeout();
  endtask : poll
  task automatic cmd(input logic [31:0] c);
    logic [31:0] x;
    apb(1'b1, REG_CMD, c, x);
    poll(0);
  endtask : cmd
  task automatic cfg(input logic [9:0] w);
    logic [31:0] x;
    apb(1'b1, REG_CFG, {22'h0, w}, x);
    cmd({30'h0, OP_WRCFG});
  endtask : cfg
  initial begin
    acc_row_t r;
    int n;
    int div;
    logic [31:0] d;
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ain_a = 10'h000;
    ain_b = 10'h000;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk({24'h0, lk.int_n, lk.rd_n, lk.conv_start_strobe_n_n, lk.d_oe, sampling, pwrdn, mode}, 32'hE0);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      ain_a <= 10'h155 ^ 10'(i);
      ain_b <= 10'h2AA ^ 10'(i * 8);
      cfg(r.cwb);
      cfg(r.cwa);
      chk({30'h0, mode}, {30'h0, r.cwa[3:2]});
      if (!r.st) chk({31'h0, sampling}, 32'h1);
      if (r.st) begin
        cmd({30'h0, OP_START});
        poll(3);
        n = r.cwa[2] ? (r.cwa[5] ? CONV_DUAL_EXT : CONV_DUAL_INT) :
                       (r.cwa[5] ? CONV_MONO_EXT : CONV_MONO_INT);
        div = r.cwa[5] ? 2 * EXT_HALF : OSC_DIV;
        // two ref_clk_i cycles early or four late are allowed for edge sampling
        chk({31'h0, conv_len >= n * div - 2 && conv_len <= n * div + 4}, 32'h1);
        chk({31'h0, pwrdn}, {31'h0, r.pd});
      end
      for (int k = 0; k < r.nrd; k++) begin
        cmd((r.cwa[3:2] == MODE_MONO_INT && !r.st) ? 32'h7 : {30'h0, OP_READ});
        repeat (60) @(posedge ref_clk_i);
        apb(1'b0, REG_DATA, 32'h0, d);
        if (r.chk[k]) chk(d, {22'h0, r.bsel[k] ? ain_b : ain_a});
      end
      if (!r.st) chk({31'h0, pwrdn}, {31'h0, r.pd});
      if (!r.st) chk({31'h0, sampling}, 32'h1);
    end
    cfg(10'h150);
    cfg(10'h004);
    apb(1'b0, REG_STAT, 32'h0, d);
    chk({31'h0, d[2]}, 32'h1);
    chk({30'h0, mode}, {30'h0, MODE_MONO_INT});
    cfg(10'h140);
    cfg(10'h004);
    n = busy_cnt;
    cmd({30'h0, OP_READ});
    repeat (30) @(posedge ref_clk_i);
    chk(32'(busy_cnt - n), 32'h0);
    cfg(10'h100);
    cfg(10'h000);
    n = busy_cnt;
    cmd({30'h0, OP_START});
    repeat (30) @(posedge ref_clk_i);
    chk(32'(busy_cnt - n), 32'h0);
    cfg(10'h140);
    cfg(10'h024);
    n = int_falls;
    cmd({30'h0, OP_START});
    cmd({30'h0, OP_START});
    poll(3);
    repeat (100) @(posedge ref_clk_i);
    chk(32'(int_falls - n), 32'h1);
    // a restarted conversion would run the full dual length from the second start
    chk({31'h0, conv_len < CONV_DUAL_EXT * 2 * EXT_HALF - 2}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk({24'h0, lk.int_n, lk.rd_n, lk.conv_start_strobe_n_n, lk.d_oe, sampling, pwrdn, mode}, 32'hE0);
    apb(1'b0, 8'h10, 32'h0, d);
    chk({d[30:0], last_err}, 32'h1);
    tally_and_finish();
  end
endmodule : adc_conversion_trigger_control_bench
